// ### hdl/fan_pwm_map.vh
// register offsets, field positions, reset values and timing counts for the fan drive block
`ifndef FAN_PWM_MAP_VH
`define FAN_PWM_MAP_VH
`define REG_DUTY_OUT1    8'h32
`define REG_DUTY_OUT2    8'h33
`define REG_DUTY_OUT3    8'h34
`define REG_DUTY_OUT4    8'h35
`define REG_CFG_PAIR_A   8'h68
`define REG_CFG_PAIR_B   8'h69
`define REG_FAN_FAULT    8'h6A
`define REG_DRIVE_SEL    8'h6B
`define DUTY_RESET       8'hFF
`define CFG_RESET        8'h00
`define FULL_DUTY_LEVEL  8'hFF
`define BIT_AUTO_FIRST   7
`define BIT_AUTO_SECOND  6
`define BIT_POL_FIRST    5
`define BIT_POL_SECOND   4
`define CFG_LIVE_MASK    8'hF0
`define CLK_HZ           100000000
`define TIMEOUT_S        2
`define TIMEOUT_CYCLES   (`CLK_HZ * `TIMEOUT_S)
`define HF_PWM_HZ        25000
`define LF_PWM_HZ        1400
`define HF_STEP_DIV      (`CLK_HZ / (`HF_PWM_HZ * 256))
`define LF_STEP_DIV      (`CLK_HZ / (`LF_PWM_HZ * 256))
`define SPINUP_PULSES    2
`endif

// ### hdl/fan_channel.v
// one fan output: pwm compare, polarity, spin-up and start-up timeout
`include "fan_pwm_map.vh"
module fan_channel #(
  parameter [31:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_step,
  input  wire [7:0] i_phase,
  input  wire [7:0] i_duty,
  input  wire       i_invert,
  input  wire       i_force_full,
  input  wire       i_tach,
  input  wire       i_start,
  output reg        o_spinning,
  output reg        o_fault,
  output reg        o_drive
);
  reg  [1:0]  pulses_q;
  reg         tach_q;
  reg  [31:0] timer_q;
  wire        tach_rise = i_tach & ~tach_q;
  wire        full_now  = i_force_full | o_spinning;
  wire        active    = full_now ? 1'b1 :
                          (i_duty == `FULL_DUTY_LEVEL) ? 1'b1 : (i_phase < i_duty);

  // spin-up holds full duty until two tach edges, timeout raises fault
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulses_q   <= 2'h0;
      tach_q     <= 1'b1; // idle tach level, so no false edge after reset
      timer_q    <= 32'h0;
      o_spinning <= 1'b0;
      o_fault    <= 1'b0;
    end else begin
      tach_q <= i_tach;
      if (i_start) begin
        o_spinning <= 1'b1;
        pulses_q   <= 2'h0;
        timer_q    <= 32'h0;
        o_fault    <= 1'b0;
      end else if (o_spinning) begin
        if (tach_rise) begin
          pulses_q <= pulses_q + 2'h1;
          if (pulses_q + 2'h1 >= `SPINUP_PULSES) begin
            o_spinning <= 1'b0;
          end
        end
        if (timer_q >= TIMEOUT_CYCLES - 32'h1) begin
          o_spinning <= 1'b0;
          o_fault    <= 1'b1;
        end else begin
          timer_q <= timer_q + 32'h1;
        end
      end
    end
  end

  // output register; polarity flips the active level
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drive <= 1'b1;
    end else if (i_step | full_now) begin
      o_drive <= active ^ i_invert;
    end
  end
endmodule // fan_channel

// ### hdl/fan_pwm_output_control.v
// four-channel fan drive: register port, mode select, pwm timebase, bus watchdog
`include "fan_pwm_map.vh"
module fan_pwm_output_control #(
  parameter [31:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  input  wire [7:0]  i_auto_speed_a,
  input  wire [7:0]  i_auto_speed_b,
  input  wire [7:0]  i_auto_speed_c,
  input  wire [7:0]  i_auto_speed_d,
  input  wire [3:0]  i_tach,
  input  wire [3:0]  i_spin_start,
  output wire        o_fan_drive_a,
  output wire        o_fan_drive_b,
  output wire        o_fan_drive_c,
  output wire        o_fan_drive_d,
  output wire [3:0]  o_fan_fault,
  output wire        o_failsafe
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rst_n = rst_sync_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  reg  [7:0]  duty_now_out1_q;
  reg  [7:0]  duty_now_out2_q;
  reg  [7:0]  duty_now_out3_q;
  reg  [7:0]  duty_now_out4_q;
  reg  [7:0]  output_config_pair_a_q;
  reg  [7:0]  output_config_pair_b_q;
  reg         low_freq_q;
  reg  [31:0] idle_q;
  reg         failsafe_q;
  wire [3:0]  spinning;
  wire [3:0]  fault;

  wire auto_select_out1 = output_config_pair_a_q[`BIT_AUTO_FIRST];
  wire auto_select_out2 = output_config_pair_a_q[`BIT_AUTO_SECOND];
  wire auto_select_out3 = output_config_pair_b_q[`BIT_AUTO_FIRST];
  wire auto_select_out4 = output_config_pair_b_q[`BIT_AUTO_SECOND];
  wire polarity_out1    = output_config_pair_a_q[`BIT_POL_FIRST];
  wire polarity_out2    = output_config_pair_a_q[`BIT_POL_SECOND];
  wire polarity_out3    = output_config_pair_b_q[`BIT_POL_FIRST];
  wire polarity_out4    = output_config_pair_b_q[`BIT_POL_SECOND];

  // manual writes land directly, auto mode tracks the external speed request
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_now_out1_q        <= `DUTY_RESET;
      duty_now_out2_q        <= `DUTY_RESET;
      duty_now_out3_q        <= `DUTY_RESET;
      duty_now_out4_q        <= `DUTY_RESET;
      output_config_pair_a_q <= `CFG_RESET;
      output_config_pair_b_q <= `CFG_RESET;
      low_freq_q             <= 1'b0;
    end else begin
      if (auto_select_out1) duty_now_out1_q <= i_auto_speed_a;
      else if (i_reg_wr && i_reg_addr == `REG_DUTY_OUT1) duty_now_out1_q <= i_reg_wdata;
      if (auto_select_out2) duty_now_out2_q <= i_auto_speed_b;
      else if (i_reg_wr && i_reg_addr == `REG_DUTY_OUT2) duty_now_out2_q <= i_reg_wdata;
      if (auto_select_out3) duty_now_out3_q <= i_auto_speed_c;
      else if (i_reg_wr && i_reg_addr == `REG_DUTY_OUT3) duty_now_out3_q <= i_reg_wdata;
      if (auto_select_out4) duty_now_out4_q <= i_auto_speed_d;
      else if (i_reg_wr && i_reg_addr == `REG_DUTY_OUT4) duty_now_out4_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `REG_CFG_PAIR_A)
        output_config_pair_a_q <= i_reg_wdata & `CFG_LIVE_MASK;
      if (i_reg_wr && i_reg_addr == `REG_CFG_PAIR_B)
        output_config_pair_b_q <= i_reg_wdata & `CFG_LIVE_MASK;
      if (i_reg_wr && i_reg_addr == `REG_DRIVE_SEL)
        low_freq_q <= i_reg_wdata[0];
    end
  end

  // read mux; the duty registers hold the applied value in either mode
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_DUTY_OUT1:  o_reg_rdata <= duty_now_out1_q;
        `REG_DUTY_OUT2:  o_reg_rdata <= duty_now_out2_q;
        `REG_DUTY_OUT3:  o_reg_rdata <= duty_now_out3_q;
        `REG_DUTY_OUT4:  o_reg_rdata <= duty_now_out4_q;
        `REG_CFG_PAIR_A: o_reg_rdata <= output_config_pair_a_q;
        `REG_CFG_PAIR_B: o_reg_rdata <= output_config_pair_b_q;
        `REG_FAN_FAULT:  o_reg_rdata <= {fault, 4'h0};
        `REG_DRIVE_SEL:  o_reg_rdata <= {7'h00, low_freq_q};
        default:         o_reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus watchdog: any access restarts the two-second window
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q     <= 32'h0;
      failsafe_q <= 1'b0;
    end else if (i_reg_wr | i_reg_rd) begin
      idle_q     <= 32'h0;
      failsafe_q <= 1'b0;
    end else if (idle_q >= TIMEOUT_CYCLES - 32'h1) begin
      failsafe_q <= 1'b1;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
  assign o_failsafe = failsafe_q;

  ////////////////////////////////////////////////////////////////////////////
  // shared pwm timebase; 256 steps per period, divider picks the rate
  reg  [15:0] div_q;
  reg  [7:0]  phase_q;
  // divider end points kept as 32-bit words and cut on purpose to the counter width
  wire [31:0] lf_max  = `LF_STEP_DIV - 1;
  wire [31:0] hf_max  = `HF_STEP_DIV - 1;
  wire [15:0] div_max = low_freq_q ? lf_max[15:0] : hf_max[15:0];
  wire        step    = (div_q >= div_max);

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q   <= 16'h0;
      phase_q <= 8'h00;
    end else if (step) begin
      div_q   <= 16'h0;
      phase_q <= phase_q + 8'h01;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  wire [31:0] duty_bus = {duty_now_out4_q, duty_now_out3_q, duty_now_out2_q, duty_now_out1_q};
  wire [3:0]  pol_bus  = {polarity_out4, polarity_out3, polarity_out2, polarity_out1};
  wire [3:0]  drv;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch
      fan_channel #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_ch (
        .i_clk        (i_clk),
        .i_rst_n      (rst_n),
        .i_step       (step),
        .i_phase      (phase_q),
        .i_duty       (duty_bus[g*8 +: 8]),
        .i_invert     (pol_bus[g]),
        .i_force_full (failsafe_q),
        .i_tach       (i_tach[g]),
        .i_start      (i_spin_start[g]),
        .o_spinning   (spinning[g]),
        .o_fault      (fault[g]),
        .o_drive      (drv[g])
      );
    end
  endgenerate

  assign o_fan_drive_a = drv[0];
  assign o_fan_drive_b = drv[1];
  assign o_fan_drive_c = drv[2];
  assign o_fan_drive_d = drv[3];
  assign o_fan_fault   = fault;
endmodule // fan_pwm_output_control

// ### testbench/fan_model.sv
// behavioural fans returning tach pulses
module fan_model #(
  parameter int HALF = 100
) (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_alive,
  output logic      [3:0] o_tach
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial o_tach = 4'hF;
  // a dead fan rests at the pull-up level, so it never gives a rising edge
  always @(posedge i_clk) begin
    cnt = (cnt + 1) % HALF;
    for (int i = 0; i < 4; i++)
      o_tach[i] <= i_alive[i] ? o_tach[i] ^ (cnt == 0) : 1'b1;
  end
endmodule // fan_model

// ### testbench/fan_pwm_output_control_asserts.sv
// port-level assertions for the fan drive block
module fan_pwm_output_control_asserts #(
  parameter [31:0] TIMEOUT_CYCLES = 32'h3E8
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [3:0] i_spin_start,
  input wire logic       o_fan_drive_a,
  input wire logic [3:0] o_fan_fault,
  input wire logic       o_failsafe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cfg_a_q;
  logic [31:0] idle_q;
  logic [31:0] spin_q;
  // own mirror of the first config register, so no design internals are needed
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) begin
      cfg_a_q <= 8'h00;
      idle_q  <= 32'h0;
      spin_q  <= 32'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'h68) cfg_a_q <= i_reg_wdata;
      idle_q <= (i_reg_wr || i_reg_rd) ? 32'h0 : idle_q + 32'h1;
      spin_q <= i_spin_start[1] ? 32'h0 : spin_q + 32'h1;
    end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_spin;
    i_spin_start[0] ##1 1'b1;
  endsequence
  sequence s_held;
    (o_fan_drive_a != cfg_a_q[5]) [*4];
  endsequence
  a_cfg_low_zero: assert property (
    i_reg_rd && i_reg_addr == 8'h68 |=> o_reg_rdata[3:0] == 4'h0) else $error("cfg low bits");
  a_duty_readback: assert property (
    i_reg_wr && i_reg_addr == 8'h32 && !cfg_a_q[7] ##2 i_reg_rd && i_reg_addr == 8'h32
    |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("duty readback");
  a_idle_failsafe: assert property (
    idle_q > TIMEOUT_CYCLES + 4 |-> o_failsafe) else $error("failsafe late");
  a_access_clears: assert property (
    i_reg_wr || i_reg_rd |-> ##2 !o_failsafe) else $error("failsafe stuck");
  a_failsafe_full: assert property (
    o_failsafe && $past(o_failsafe, 2) |-> o_fan_drive_a != cfg_a_q[5]) else $error("not full");
  a_spin_clears: assert property (
    i_spin_start[1] |=> !o_fan_fault[1]) else $error("fault not cleared");
  a_spin_full: assert property (
    s_spin |-> ##1 s_held) else $error("spin not full");
  a_fault_timing: assert property (
    $rose(o_fan_fault[1]) |-> spin_q >= TIMEOUT_CYCLES - 2 && spin_q <= TIMEOUT_CYCLES + 4)
    else $error("fault timing");
endmodule // fan_pwm_output_control_asserts

// ### testbench/fan_pwm_output_control_tb.sv
// self-checking bench for the fan drive block
`include "fan_pwm_map.vh"
module fan_pwm_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TO   = 32'h1770;
  localparam logic [31:0] STEP = `HF_STEP_DIV;
  localparam logic [31:0] PER  = 256 * STEP;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, spd = 8'h00;
  logic [3:0] tach, fault, spin = 4'h0, alive = 4'hD;
  logic       da, db, dc, dd, fs;
  logic [7:0] duty [4];
  logic [7:0] cfg [2];
  logic [31:0] lf = 32'd67986;
  int n_fail = 0, n_checks = 0;
  wire [3:0] drv = {dd, dc, db, da};
  always #5 clk = ~clk;
  fan_pwm_output_control #(.TIMEOUT_CYCLES(TO)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_auto_speed_a(spd), .i_auto_speed_b(spd), .i_auto_speed_c(spd), .i_auto_speed_d(spd),
    .i_tach(tach), .i_spin_start(spin), .o_fan_drive_a(da), .o_fan_drive_b(db),
    .o_fan_drive_c(dc), .o_fan_drive_d(dd), .o_fan_fault(fault), .o_failsafe(fs));
  fan_model i_fans (.i_clk(clk), .i_alive(alive), .o_tach(tach));
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  // active cycles per period from duty or auto speed; full code never drops
  function automatic logic [31:0] ex_on(int i);
    logic [7:0] d;
    d = cfg[i/2][7-i%2] ? spd : duty[i];
    return d == 8'hFF ? PER : d * STEP;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one strobe cycle, entered and left at a falling edge
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    wr = w; rd = !w; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0; rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("reg", e, rdata);
  endtask
  task automatic cfgw(logic [7:0] a, logic [7:0] b);
    cfg[0] = a; cfg[1] = b;
    acc(1'b1, 8'h68, a);
    acc(1'b1, 8'h69, b);
    rdchk(8'h68, a);
    rdchk(8'h69, b);
  endtask
  // count active cycles over exactly one period, any phase
  task automatic meas();
    int c [4] = '{0, 0, 0, 0};
    repeat (40) @(negedge clk);
    repeat (PER) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) c[i] += (drv[i] === ~cfg[i/2][5-i%2]);
    end
    for (int i = 0; i < 4; i++) chk("active", ex_on(i), c[i]);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) rdchk(8'(8'h32 + i), 8'hFF);
    rdchk(8'h00, 8'h00);
    cfgw(8'h20, 8'h10);
    acc(1'b1, 8'h6B, 8'h01);
    rdchk(8'h6B, 8'h01);
    acc(1'b1, 8'h6B, 8'h00);
    rdchk(8'h6B, 8'h00);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 4; i++) begin
        duty[i] = r == 0 ? rnd() : (r == 1 ? 8'h00 : 8'hFF);
        acc(1'b1, 8'(8'h32 + i), duty[i]);
        rdchk(8'(8'h32 + i), duty[i]);
      end
      meas();
    end
    spd = rnd();
    cfgw(8'hE0, 8'hD0);
    acc(1'b1, 8'h34, 8'h11);
    for (int i = 0; i < 4; i++) rdchk(8'(8'h32 + i), spd);
    meas();
    cfgw(8'h20, 8'h10);
    repeat (TO + 10) @(negedge clk);
    chk("failsafe", 1, fs);
    chk("drive", 4'h6, drv);
    rdchk(8'h00, 8'h00);
    @(negedge clk);
    chk("failsafe", 0, fs);
    for (int i = 0; i < 2; i++) acc(1'b1, 8'(8'h32 + i), 8'h00);
    spin = 4'h3;
    @(negedge clk);
    spin = 4'h0;
    repeat (3) @(negedge clk);
    chk("spin drive", 2'b10, drv[1:0]);
    for (int k = 0; k < 1000 && drv[0] !== 1'b1; k++) @(negedge clk);
    chk("spun", 1, drv[0]);
    if (drv[0] !== 1'b1) summarize();
    repeat (7) begin
      repeat (1000) @(negedge clk);
      acc(1'b0, 8'h00, 8'h00);
    end
    chk("fault", 4'h2, fault);
    rdchk(8'h6A, 8'h20);
    summarize();
  end
endmodule // fan_pwm_output_control_tb
bind fan_pwm_output_control fan_pwm_output_control_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_spin_start(i_spin_start), .o_fan_drive_a(o_fan_drive_a), .o_fan_fault(o_fan_fault),
  .o_failsafe(o_failsafe));
